// ### rtl/duty_ratio_square_wave_gen.sv
// Purpose: two channel duty ratio square wave generator behind an APB slave
// Assumes: APB inputs synchronous to I_CLK, zero wait state slave
// Notes: wave and done outputs are registered, so they follow the engine by one cycle
// Function
// [RQ1] enable high drives wave, low forces 0
// [RQ2] instance zero on channel zero, one on one
// [RQ3] channel owned by one generator kind only
// [RQ4] period is preset times time base
// [RQ5] time base fixed while generator enabled
// [RQ6] preset range depends on time base
// [RQ7] new period applied at period end
// [RQ8] zero or illegal preset stops generation
// [RQ9] high width is period times ratio/100
// [RQ10] ratio zero stops, output held 0
// [RQ11] ratio 100 holds output at 1
// [RQ12] new ratio applied at period end
// [RQ13] ratio above 100 clamps, negative becomes 0
// [RQ14] ratio word 16 bits, resets to 0
// [RQ15] pulse count zero means unlimited pulses
// [RQ16] done on count reached, cleared by enable/reset
// [RQ17] cold restart stops, output 0, defaults back
// [RQ18] controller stop: hold output or fallback value
// [RQ19] time base tick advances period counter
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
module duty_ratio_square_wave_gen #(
   parameter int TB0_CYCLES = duty_gen_pkg::TB_0P1MS_CYC,
   parameter int TB1_CYCLES = duty_gen_pkg::TB_1MS_CYC,
   parameter int TB2_CYCLES = duty_gen_pkg::TB_10MS_CYC,
   parameter int TB3_CYCLES = duty_gen_pkg::TB_1S_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [duty_gen_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_IRQ,
   output logic O_OUTPUT_CHANNEL_ZERO,
   output logic O_OUTPUT_CHANNEL_ONE,
   output logic [duty_gen_pkg::NUM_CH-1:0] O_GENERATION_DONE_FLAG
);
   import duty_gen_pkg::*;

   function automatic logic [15:0] preset_max(input time_base_t tb);
      logic [15:0] m;
      m = PMAX_1S;
      unique case (tb)
         TB_0P1MS: m = PMAX_0P1MS;
         TB_1MS: m = PMAX_1MS;
         TB_10MS: m = PMAX_10MS;
         TB_1S: m = PMAX_1S;
      endcase
      return m;
   endfunction : preset_max

   function automatic logic [DIV_W-1:0] tick_limit(input time_base_t tb);
      logic [DIV_W-1:0] l;
      l = DIV_W'(TB3_CYCLES - 1);
      unique case (tb)
         TB_0P1MS: l = DIV_W'(TB0_CYCLES - 1);
         TB_1MS: l = DIV_W'(TB1_CYCLES - 1);
         TB_10MS: l = DIV_W'(TB2_CYCLES - 1);
         TB_1S: l = DIV_W'(TB3_CYCLES - 1);
      endcase
      return l;
   endfunction : tick_limit

   function automatic logic [15:0] ratio_fix(input logic [15:0] d);
      logic [15:0] r;
      r = d;
      if (d[15]) begin
         r = 16'h0000; // [RQ13]
      end else if (d > RATIO_FULL) begin
         r = RATIO_FULL; // [RQ13]
      end
      return r;
   endfunction : ratio_fix

   function automatic logic [31:0] count_fix(input logic dword,
                                             input logic [31:0] d);
      logic [31:0] c;
      c = d;
      if (dword && d[31]) begin
         c = 32'h0000_0000;
      end else if (!dword) begin
         c = d[15] ? 32'h0000_0000 : {17'h0_0000, d[14:0]};
      end
      return c;
   endfunction : count_fix

   // bus decode
   wire logic acc = I_PSEL & I_PENABLE;
   wire logic wr = acc & I_PWRITE;
   wire logic rd = acc & ~I_PWRITE;
   wire logic in_chan = I_PADDR < (CH_STRIDE * ADDR_W'(NUM_CH));
   wire logic [1:0] sel = I_PADDR[3:2];
   wire logic word_ok = I_PADDR[1:0] == 2'h0;
   wire logic hit_glb = I_PADDR == ADDR_GLOBAL;
   wire logic hit_live = I_PADDR == ADDR_LIVE;
   wire logic hit_stat = I_PADDR == ADDR_IRQ_STAT;
   wire logic hit_mask = I_PADDR == ADDR_IRQ_MASK;
   wire logic mapped = word_ok & (in_chan | hit_glb | hit_live |
                                  hit_stat | hit_mask);

   logic [1:0] glb;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_set;
   logic [NUM_CH-1:0] chan_out;
   logic [NUM_CH-1:0] done;
   logic [NUM_CH-1:0] running;
   logic [31:0] chan_rd [NUM_CH];
   chan_cfg_t cfg [NUM_CH];

   wire logic halt = glb[GLB_STOP];
   wire logic hold = glb[GLB_HOLD];

   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         wire logic ch_hit = word_ok & in_chan &
                             (I_PADDR[4] == 1'(i));
         wire logic wr_per = wr & ch_hit & (sel == SEL_PERIOD);
         wire logic wr_rat = wr & ch_hit & (sel == SEL_RATIO);
         wire logic wr_cnt = wr & ch_hit & (sel == SEL_COUNT);
         wire logic wr_ctl = wr & ch_hit & (sel == SEL_CTRL);
         wire logic per_bad = I_PWDATA[15:0] > preset_max(cfg[i].tb);
         wire logic count_rst = wr_ctl & I_PWDATA[CTL_CRST];

         always_ff @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               // defaults come back on cold restart
               cfg[i].period <= RST_PERIOD; // [RQ17]
               cfg[i].ratio <= RST_RATIO; // [RQ14]
               cfg[i].count <= RST_COUNT;
               cfg[i].enable <= 1'b0;
               cfg[i].dword <= 1'b0;
               cfg[i].tb <= RST_TB;
               cfg[i].fallback <= 1'b0;
            end else begin
               if (wr_per) begin
                  // illegal preset forced to zero
                  cfg[i].period <= per_bad ? 16'h0000 :
                                   I_PWDATA[15:0]; // [RQ6] [RQ8]
               end
               if (wr_rat) begin
                  cfg[i].ratio <= ratio_fix(I_PWDATA[15:0]); // [RQ13]
               end
               if (wr_cnt) begin
                  cfg[i].count <= count_fix(cfg[i].dword, I_PWDATA);
               end
               if (wr_ctl) begin
                  cfg[i].enable <= I_PWDATA[CTL_EN];
                  cfg[i].dword <= I_PWDATA[CTL_DWORD];
                  cfg[i].fallback <= I_PWDATA[CTL_FALLBACK];
                  if (!cfg[i].enable) begin
                     cfg[i].tb <= time_base_t'(
                        I_PWDATA[CTL_TB_LO+1:CTL_TB_LO]); // [RQ5]
                  end
               end
            end
         end

         // engine
         gen_state_t state;
         logic [DIV_W-1:0] tdiv;
         logic [15:0] pc;
         logic [15:0] act_p;
         logic [15:0] act_r;
         logic [30:0] pulses;
         logic [30:0] goal;
         logic en_q;
         logic out;

         wire logic en = cfg[i].enable & ~halt;
         wire logic en_rise = en & ~en_q;
         wire logic live_ok = (cfg[i].period != 16'h0000) &
                              (cfg[i].ratio != 16'h0000); // [RQ8] [RQ10]
         wire logic [30:0] goal_live = cfg[i].dword ? cfg[i].count[30:0] :
                                       {16'h0000, cfg[i].count[14:0]};
         wire logic tick = tdiv == tick_limit(cfg[i].tb); // [RQ19]
         wire logic pc_last = pc == (act_p - 16'h0001); // [RQ4]
         wire logic goal_hit = (goal != 31'h0000_0000) &
                               (pulses + 31'h0000_0001 == goal); // [RQ15]
         wire logic in_run = state == ST_RUN;
         wire logic fin = in_run & en & tick & pc_last & goal_hit;
         wire logic [23:0] pc_scaled = 24'(pc) * 24'(PCT_SCALE);
         wire logic [23:0] high_lim = 24'(act_p) * 24'(act_r); // [RQ9]
         wire logic run_high = in_run & ((act_r >= RATIO_FULL) |
                               (pc_scaled < high_lim)); // [RQ9] [RQ11]
         wire logic next_out = halt ? (hold ? out : cfg[i].fallback) :
                               (en & run_high); // [RQ1] [RQ18]

         always_ff @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               state <= ST_IDLE; // [RQ17]
               tdiv <= '0;
               pc <= 16'h0000;
               act_p <= 16'h0000;
               act_r <= 16'h0000;
               pulses <= 31'h0000_0000;
               goal <= 31'h0000_0000;
               en_q <= 1'b0;
               out <= 1'b0; // [RQ17]
            end else begin
               en_q <= en;
               out <= next_out;
               unique case (state)
                  ST_IDLE: begin
                     tdiv <= '0;
                     pc <= 16'h0000;
                     pulses <= 31'h0000_0000;
                     if (en && live_ok) begin
                        state <= ST_RUN;
                        act_p <= cfg[i].period;
                        act_r <= cfg[i].ratio;
                        goal <= goal_live;
                     end
                  end
                  ST_RUN: begin
                     if (!en) begin
                        state <= ST_IDLE; // [RQ1] [RQ18]
                     end else if (tick) begin
                        tdiv <= '0;
                        if (!pc_last) begin
                           pc <= pc + 16'h0001; // [RQ19]
                        end else if (goal_hit) begin
                           state <= ST_DONE; // [RQ16]
                        end else begin
                           pc <= 16'h0000;
                           pulses <= pulses + 31'h0000_0001;
                           // shadow values only swap at a period boundary
                           act_p <= cfg[i].period; // [RQ7]
                           act_r <= cfg[i].ratio; // [RQ12]
                           if (!live_ok) begin
                              state <= ST_IDLE; // [RQ8] [RQ10]
                           end
                        end
                     end else begin
                        tdiv <= tdiv + DIV_W'(1);
                     end
                     if (count_rst) begin
                        pulses <= 31'h0000_0000;
                        goal <= goal_live;
                     end
                  end
                  ST_DONE: begin
                     if (en_rise || count_rst) begin
                        state <= ST_IDLE; // [RQ16]
                     end
                  end
               endcase
            end
         end

         assign chan_out[i] = out;
         assign done[i] = state == ST_DONE;
         assign running[i] = in_run;
         assign irq_set[i] = fin;
         assign irq_set[NUM_CH+i] = wr_per & per_bad;
         assign chan_rd[i] =
            (sel == SEL_PERIOD) ? {16'h0000, cfg[i].period} :
            (sel == SEL_RATIO) ? {16'h0000, cfg[i].ratio} :
            (sel == SEL_COUNT) ? cfg[i].count :
            {23'h00_0000, cfg[i].fallback, 2'h0, cfg[i].tb, 1'b0,
             cfg[i].dword, 1'b0, cfg[i].enable};
      end
   endgenerate

   // global control and interrupt registers
   wire logic stat_clr = rd & hit_stat;
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         glb <= 2'h0;
         irq_mask <= '0;
         irq_stat <= '0;
      end else begin
         if (wr && hit_glb) begin
            glb <= I_PWDATA[1:0];
         end
         if (wr && hit_mask) begin
            irq_mask <= I_PWDATA[IRQ_W-1:0];
         end
         // only the bits that the read reported are cleared, so an event
         // landing between setup and access, or in the access cycle, stays
         irq_stat <= (stat_clr ? irq_stat & ~O_PRDATA[IRQ_W-1:0] :
                      irq_stat) | irq_set;
      end
   end

   wire logic [31:0] live_word = {26'h000_0000, running, done, chan_out};
   wire logic [31:0] rd_word =
      in_chan ? chan_rd[I_PADDR[4]] :
      hit_glb ? {30'h0000_0000, glb} :
      hit_live ? live_word :
      hit_stat ? {28'h000_0000, irq_stat} :
      hit_mask ? {28'h000_0000, irq_mask} : 32'h0000_0000;

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_PRDATA <= 32'h0000_0000;
      end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
         O_PRDATA <= mapped ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_GENERATION_DONE_FLAG <= '0;
      end else begin
         O_GENERATION_DONE_FLAG <= done; // [RQ16]
      end
   end

   assign O_PREADY = 1'b1;
   assign O_PSLVERR = acc & ~mapped;
   assign O_IRQ = |(irq_stat & irq_mask);
   // each instance owns its own dedicated channel
   assign O_OUTPUT_CHANNEL_ZERO = chan_out[0]; // [RQ2]
   assign O_OUTPUT_CHANNEL_ONE = chan_out[1]; // [RQ2]
endmodule : duty_ratio_square_wave_gen

// ### rtl/duty_gen_pkg.sv
// Purpose: shared constants and types of the duty ratio square wave generator
// Assumes: 125 MHz system clock, APB register access
// Notes: register offsets are byte addresses, one 32-bit word each
package duty_gen_pkg;
   localparam int NUM_CH = 2;
   localparam int ADDR_W = 8;
   localparam int DIV_W = 27;
   // clock and time bases in nanoseconds
   localparam int CLK_PERIOD_NS = 8;
   localparam int TB_0P1MS_NS = 100000;
   localparam int TB_1MS_NS = 1000000;
   localparam int TB_10MS_NS = 10000000;
   localparam int TB_1S_NS = 1000000000;
   localparam int TB_0P1MS_CYC = TB_0P1MS_NS / CLK_PERIOD_NS;
   localparam int TB_1MS_CYC = TB_1MS_NS / CLK_PERIOD_NS;
   localparam int TB_10MS_CYC = TB_10MS_NS / CLK_PERIOD_NS;
   localparam int TB_1S_CYC = TB_1S_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      TB_0P1MS = 2'h0,
      TB_1MS = 2'h1,
      TB_10MS = 2'h2,
      TB_1S = 2'h3
   } time_base_t;

   // largest legal preset per time base
   localparam logic [15:0] PMAX_0P1MS = 16'h2710;
   localparam logic [15:0] PMAX_1MS = 16'h03E8;
   localparam logic [15:0] PMAX_10MS = 16'h0064;
   localparam logic [15:0] PMAX_1S = 16'h0001;
   localparam logic [15:0] RATIO_FULL = 16'h0064;
   localparam logic [7:0] PCT_SCALE = 8'h64;

   // register offsets: per channel block plus global registers
   localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h10;
   localparam logic [1:0] SEL_PERIOD = 2'h0;
   localparam logic [1:0] SEL_RATIO = 2'h1;
   localparam logic [1:0] SEL_COUNT = 2'h2;
   localparam logic [1:0] SEL_CTRL = 2'h3;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_LIVE = 8'h24;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h28;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h2C;

   // channel control fields
   localparam int CTL_EN = 0;
   localparam int CTL_CRST = 1;
   localparam int CTL_DWORD = 2;
   localparam int CTL_TB_LO = 4;
   localparam int CTL_FALLBACK = 8;
   // global control fields
   localparam int GLB_STOP = 0;
   localparam int GLB_HOLD = 1;
   localparam int IRQ_W = 2 * NUM_CH;

   // cold restart values
   localparam logic [15:0] RST_PERIOD = 16'h0000;
   localparam logic [15:0] RST_RATIO = 16'h0000;
   localparam logic [31:0] RST_COUNT = 32'h0000_0000;
   localparam time_base_t RST_TB = TB_1MS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } gen_state_t;

   typedef struct packed {
      logic [15:0] period;
      logic [15:0] ratio;
      logic [31:0] count;
      logic enable;
      logic dword;
      time_base_t tb;
      logic fallback;
   } chan_cfg_t;
endpackage : duty_gen_pkg

// ### testbench/duty_gen_monitor.sv
// Purpose: port checker of the duty ratio square wave generator
// Assumes: zero wait state APB slave, one clock domain
// Notes: bound to the top module after the endmodule
`timescale 1ns/100ps
module duty_gen_monitor (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [duty_gen_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic O_IRQ,
   input wire logic O_OUTPUT_CHANNEL_ZERO,
   input wire logic O_OUTPUT_CHANNEL_ONE,
   input wire logic [duty_gen_pkg::NUM_CH-1:0] O_GENERATION_DONE_FLAG
);
   wire acc = I_PSEL && I_PENABLE;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   a_pready_high: assert property (
      O_PREADY) else $error("pready low");
   a_slverr_phase: assert property (
      O_PSLVERR |-> acc) else $error("slverr outside access");
   a_slverr_align: assert property (
      acc && I_PADDR[1:0] != 2'h0 |-> O_PSLVERR) else $error("unaligned ok");
   a_slverr_hole: assert property (
      acc && !I_PWRITE && I_PADDR > 8'h2C |-> O_PSLVERR
      && O_PRDATA == 32'h0000_0000) else $error("unmapped read ok");
   a_prdata_hold: assert property (
      acc && !I_PWRITE |=> $stable(O_PRDATA)) else $error("rdata moved");
   a_reset_quiet: assert property (
      !$past(I_RESET_N) |-> !O_OUTPUT_CHANNEL_ZERO && !O_OUTPUT_CHANNEL_ONE
      && !O_IRQ && O_GENERATION_DONE_FLAG == 2'h0) else $error("reset out");
   a_done_idle: assert property (
      O_GENERATION_DONE_FLAG[0] |-> !O_OUTPUT_CHANNEL_ZERO)
      else $error("output high while done");
   a_disable_low: assert property (
      acc && I_PWRITE && I_PADDR == 8'h0C && !I_PWDATA[0]
      |-> ##2 !O_OUTPUT_CHANNEL_ZERO [*2]) else $error("disabled high");
endmodule : duty_gen_monitor

bind duty_ratio_square_wave_gen duty_gen_monitor u_duty_gen_monitor (
   .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ),
   .O_OUTPUT_CHANNEL_ZERO(O_OUTPUT_CHANNEL_ZERO),
   .O_OUTPUT_CHANNEL_ONE(O_OUTPUT_CHANNEL_ONE),
   .O_GENERATION_DONE_FLAG(O_GENERATION_DONE_FLAG));

// ### testbench/field_load_model.sv
// Purpose: field load on one dedicated output channel
// Assumes: line sampled at the rising clock edge
// Notes: reports high width, period length and pulse count in cycles
`timescale 1ns/100ps
module field_load_model (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_line,
   output int o_high,
   output int o_period,
   output int o_n_high,
   output int o_n_period,
   output int o_pulses
);
   int hi_run;
   int per_run;
   logic prev;
   // the load listens to this generator alone, never a second driver
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hi_run = 0;
         per_run = 0;
         prev = 1'b0;
         o_n_high <= 0;
         o_n_period <= 0;
         o_pulses <= 0;
      end else begin
         if (i_line && !prev) begin
            o_period <= per_run;
            o_n_period <= o_n_period + 1;
            o_pulses <= o_pulses + 1;
            per_run = 0;
         end
         if (!i_line && prev) begin
            o_high <= hi_run;
            o_n_high <= o_n_high + 1;
            hi_run = 0;
         end
         per_run = per_run + 1;
         if (i_line) hi_run = hi_run + 1;
         prev = i_line;
      end
   end
endmodule : field_load_model

// ### testbench/duty_ratio_square_wave_gen_tb_top.sv
// Purpose: self-checking bench of the duty ratio square wave generator
// Assumes: tick lengths shortened to 4, 6, 8 and 10 cycles
// Notes: expectations come from an integer model of the wave
`timescale 1ns/100ps
module duty_ratio_square_wave_gen_tb_top;
   logic clk, rst_n, psel, pen, pwr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, q;
   wire [31:0] prdata;
   wire pready, pslverr, irq, out0, out1;
   wire [1:0] done;
   int hi[2], per[2], nh[2], np[2], pls[2];
   int bad_count, comparisons, cyc, seed, h, p, n, k, v;
   int tc[4] = '{4, 6, 8, 10};
   int pmax[4] = '{10000, 1000, 100, 1};
   int tbv[6] = '{0, 0, 1, 1, 2, 3};
   int pv[6] = '{10000, 10001, 1000, 1001, 101, 2};
   int rtab[5] = '{50, 150, 32'h8005, 100, 0};
   logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h2C, 8'h28};
   logic [31:0] rv[7] = '{0, 0, 0, 32'h0000_0010, 0, 0, 0};
   duty_ratio_square_wave_gen #(.TB0_CYCLES(4), .TB1_CYCLES(6),
      .TB2_CYCLES(8), .TB3_CYCLES(10)) u_duty_ratio_square_wave_gen (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq),
      .O_OUTPUT_CHANNEL_ZERO(out0), .O_OUTPUT_CHANNEL_ONE(out1),
      .O_GENERATION_DONE_FLAG(done));
   field_load_model u_field_load_model_0 (.i_clk(clk), .i_reset_n(rst_n),
      .i_line(out0), .o_high(hi[0]), .o_period(per[0]),
      .o_n_high(nh[0]), .o_n_period(np[0]), .o_pulses(pls[0]));
   field_load_model u_field_load_model_1 (.i_clk(clk), .i_reset_n(rst_n),
      .i_line(out1), .o_high(hi[1]), .o_period(per[1]),
      .o_n_high(nh[1]), .o_n_period(np[1]), .o_pulses(pls[1]));
   task complete_run;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t word %h expected %h", $time, g, x);
      end
   endtask : chk
   task chk_b(input logic g, input logic x);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t flag %b expected %b", $time, g, x);
      end
   endtask : chk_b
   task chk_n(input int g, input int x);
      comparisons++;
      if (g != x) begin
         bad_count++;
         $display("[ERR] %0t length %0d expected %0d", $time, g, x);
      end
   endtask : chk_n
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask : rd
   task meas(input int c, output int hv, output int pvl);
      int a, b;
      a = nh[c];
      while (nh[c] == a) @(posedge clk);
      b = np[c];
      while (np[c] == b) @(posedge clk);
      hv = hi[c];
      pvl = per[c];
   endtask : meas
   task hold(input logic lv, input int cnt);
      int m;
      m = 0;
      repeat (cnt) begin
         @(posedge clk);
         if (out0 !== lv) m++;
      end
      chk_n(m, 0);
   endtask : hold
   function int hexp(input int t, input int pp, input int r);
      return t * ((pp * r + 99) / 100);
   endfunction : hexp
   function int rat(input int r);
      return r[15] ? 0 : (r > 100 ? 100 : r);
   endfunction : rat
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         complete_run;
      end
   end
   initial begin
      {psel, pen, pwr, paddr, pwdata, rst_n} = '0;
      seed = 32'hbe4e;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      apb(1'b0, 8'h30, 32'h0000_0000);
      chk_b(e, 1'b1);
      chk(q, 32'h0000_0000);
      apb(1'b1, 8'h02, 32'h0000_0001);
      chk_b(e, 1'b1);
      wr(8'h2C, 32'h0000_0008);
      for (int i = 0; i < 6; i++) begin
         wr(8'h1C, tbv[i] << 4);
         wr(8'h10, pv[i]);
         rd(8'h10, pv[i] > pmax[tbv[i]] ? 0 : pv[i]);
      end
      repeat (2) @(posedge clk);
      chk_b(irq, 1'b1);
      apb(1'b0, 8'h28, 32'h0000_0000);
      chk(q & 32'h0000_0008, 32'h0000_0008);
      @(posedge clk);
      chk_b(irq, 1'b0);
      for (int i = 0; i < 9; i++) begin
         v = i < 5 ? rtab[i] : $unsigned($random(seed)) % 101;
         wr(8'h04, v);
         rd(8'h04, rat(v));
      end
      wr(8'h0C, 0);
      wr(8'h00, 5);
      wr(8'h04, 40);
      wr(8'h0C, 1);
      wr(8'h1C, 32'h0000_0010);
      wr(8'h10, 3);
      wr(8'h14, 50);
      wr(8'h1C, 32'h0000_0011);
      wr(8'h0C, 32'h0000_0021);
      rd(8'h0C, 32'h0000_0001);
      meas(1, h, p);
      meas(1, h, p);
      chk_n(h, hexp(tc[1], 3, 50));
      chk_n(p, tc[1] * 3);
      meas(0, h, p);
      meas(0, h, p);
      chk_n(h, hexp(tc[0], 5, 40));
      chk_n(p, tc[0] * 5);
      wr(8'h04, 60);
      wr(8'h00, 3);
      meas(0, h, p);
      chk_n(h, hexp(tc[0], 5, 40));
      chk_n(p, tc[0] * 5);
      meas(0, h, p);
      chk_n(h, hexp(tc[0], 3, 60));
      chk_n(p, tc[0] * 3);
      wr(8'h04, 100);
      repeat (30) @(posedge clk);
      hold(1'b1, 24);
      wr(8'h04, 0);
      repeat (30) @(posedge clk);
      hold(1'b0, 24);
      wr(8'h04, 40);
      meas(0, h, p);
      chk_n(h, hexp(tc[0], 3, 40));
      wr(8'h00, 0);
      repeat (30) @(posedge clk);
      hold(1'b0, 24);
      wr(8'h2C, 32'h0000_0001);
      wr(8'h0C, 4);
      wr(8'h08, 32'h8000_0002);
      rd(8'h08, 0);
      wr(8'h08, 32'h0001_0003);
      rd(8'h08, 32'h0001_0003);
      wr(8'h0C, 0);
      wr(8'h08, 32'h0001_0003);
      rd(8'h08, 3);
      wr(8'h08, 3);
      wr(8'h00, 5);
      n = pls[0];
      wr(8'h0C, 1);
      k = 0;
      while (done[0] !== 1'b1 && k < 500) begin
         @(posedge clk);
         k++;
      end
      chk_b(done[0], 1'b1);
      chk_n(pls[0] - n, 3);
      chk_b(out0, 1'b0);
      chk_b(irq, 1'b1);
      apb(1'b0, 8'h28, 32'h0000_0000);
      chk_b(q[0], 1'b1);
      wr(8'h08, 0);
      wr(8'h0C, 3);
      repeat (3) @(posedge clk);
      chk_b(done[0], 1'b0);
      repeat (200) @(posedge clk);
      chk_b(done[0], 1'b0);
      wr(8'h0C, 32'h0000_0101);
      wr(8'h20, 1);
      repeat (4) @(posedge clk);
      hold(1'b1, 20);
      wr(8'h20, 0);
      wr(8'h0C, 1);
      wr(8'h04, 100);
      repeat (30) @(posedge clk);
      wr(8'h20, 3);
      repeat (4) @(posedge clk);
      hold(1'b1, 20);
      complete_run;
   end
endmodule : duty_ratio_square_wave_gen_tb_top
